// file: pkg/bus_port_defines.svh
// Dual-channel bus port constants
`ifndef BUS_PORT_DEFINES_SVH
`define BUS_PORT_DEFINES_SVH

// =============================================================
// Clock and line rates
`define CLK_SYS_PERIOD_PS      5000
`define ASYNC_MAX_RATE_KBPS    5000
`define ASYNC_BIT_PERIOD_PS    (1000000000 / `ASYNC_MAX_RATE_KBPS)
// Half cell, rounded up so the rate stays a ceiling
`define ASYNC_HALF_CELL_CYCLES ((`ASYNC_BIT_PERIOD_PS + 2 * `CLK_SYS_PERIOD_PS - 1) / (2 * `CLK_SYS_PERIOD_PS))

// =============================================================
// Framing
`define BYTE_BITS              8
`define IDLE_HALF_CELLS        5
`define PIN_SYNC_WIDTH         5

// =============================================================
// Line levels
`define LINE_IDLE_LEVEL        1'b1
`define TXD_REST_LEVEL         1'b1
`define CTS_REST_LEVEL         1'b0

`endif

// file: pkg/bus_port_pkg.sv
// Bus port types
package bus_port_pkg;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SYNC,
        TX_BITS
    } tx_state_t;

    typedef enum logic {
        RX_IDLE,
        RX_ACTIVE
    } rx_state_t;

endpackage

// file: design/pin_synchroniser.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps

module pin_synchroniser #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // =============================================================
    // Only stage two reads stage one
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// file: design/two_entry_buffer.sv
// Two-entry valid/ready buffer
`timescale 1ns/1ps

module two_entry_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_SLOT  = PW'(DEPTH - 1);

    logic [WIDTH-1:0] slot [DEPTH];
    logic [PW-1:0]    wr_idx;
    logic [PW-1:0]    rd_idx;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = slot[rd_idx];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
    end

    // =============================================================
    // Storage and pointers
    always_ff @(posedge clk_sys) begin
        if (push) begin
            slot[wr_idx] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_idx <= '0;
            rd_idx <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == LAST_SLOT) ? '0 : wr_idx + PW'(1);
            end
            if (pop) begin
                rd_idx <= (rd_idx == LAST_SLOT) ? '0 : rd_idx + PW'(1);
            end
        end
    end

    // =============================================================
    // Registered flags: handshakes leave flops
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            count     <= next_count;
            in_ready  <= next_count != FULL_COUNT;
            out_valid <= next_count != '0;
        end
    end

endmodule

// file: design/dual_channel_bus_port.sv
// Dual-channel serial bus port
//
// Function
// - Two channels, each with own transmitter, receiver and mode.
// - Data and enable driven while window was set one clock earlier, else released.
// - Separate window per channel.
// - Async mode codes MFM or Manchester, at most 5 Mbit/s.
// - Receive one is idle; RS485 option also takes long zero as idle.
// - Async mode ignores bit clocks, receive error and data valid.
// - Sync mode uses an external bit clock, 5 to 25 Mbit/s.
// - Sync mode drives one lane and enable, takes clocks, error, valid, data.
// - No collision handling; frames need not be Ethernet.
`timescale 1ns/1ps
`include "bus_port_defines.svh"

module dual_channel_bus_port #(
    parameter int CHANNELS         = 2,
    parameter int DATA_W           = `BYTE_BITS,
    parameter int HALF_CELL_CYCLES = `ASYNC_HALF_CELL_CYCLES,
    parameter int IDLE_HALF_CELLS  = `IDLE_HALF_CELLS
) (
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic [CHANNELS-1:0] sync_mode,
    input  wire logic [CHANNELS-1:0] mfm_select,
    input  wire logic [CHANNELS-1:0] rs485_mode,
    input  wire logic [CHANNELS-1:0] tx_window,
    input  wire logic [DATA_W-1:0]   tx_data [CHANNELS],
    input  wire logic [CHANNELS-1:0] tx_valid,
    output logic      [CHANNELS-1:0] tx_ready,
    output logic      [DATA_W-1:0]   rx_data [CHANNELS],
    output logic      [CHANNELS-1:0] rx_data_valid,
    output logic      [CHANNELS-1:0] rx_error_seen,
    output logic      [CHANNELS-1:0] rx_frame_end,
    output logic      [CHANNELS-1:0] txd_out,
    output logic      [CHANNELS-1:0] txd_oe,
    output logic      [CHANNELS-1:0] cts_out,
    output logic      [CHANNELS-1:0] cts_oe,
    input  wire logic [CHANNELS-1:0] tx_bit_clock_in,
    input  wire logic [CHANNELS-1:0] rx_error_in,
    input  wire logic [CHANNELS-1:0] rx_bit_clock_in,
    input  wire logic [CHANNELS-1:0] rx_valid_in,
    input  wire logic [CHANNELS-1:0] rxd_in
);

    localparam int TW = $clog2(HALF_CELL_CYCLES + 1);
    localparam int BW = $clog2(DATA_W + 1);
    localparam int RW = $clog2(IDLE_HALF_CELLS + 1);
    localparam logic [TW-1:0] HALF_LAST = TW'(HALF_CELL_CYCLES - 1);
    localparam logic [TW-1:0] HALF_MID  = TW'(HALF_CELL_CYCLES / 2);
    localparam logic [BW-1:0] BYTE_LEN  = BW'(DATA_W);
    localparam logic [RW-1:0] IDLE_RUN  = RW'(IDLE_HALF_CELLS);

    // =============================================================
    // One independent unit per channel
    for (genvar g = 0; g < CHANNELS; g++) begin : chan

        logic [`PIN_SYNC_WIDTH-1:0] pins_s;
        logic                       tck_s;
        logic                       rck_s;
        logic                       rxv_s;
        logic                       rx_error_in_s;
        logic                       rxd_s;
        logic                       tck_q;
        logic                       rck_q;
        logic                       rxv_q;
        logic                       rxd_q;
        logic                       tck_fall;
        logic                       rck_rise;

        pin_synchroniser #(
            .WIDTH    (`PIN_SYNC_WIDTH)
        ) u_pins (
            .clk_sys  (clk_sys),
            .reset    (reset),
            .async_in ({tx_bit_clock_in[g], rx_bit_clock_in[g], rx_valid_in[g], rx_error_in[g], rxd_in[g]}),
            .sync_out (pins_s)
        );

        assign {tck_s, rck_s, rxv_s, rx_error_in_s, rxd_s} = pins_s;

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                tck_q <= 1'b0;
                rck_q <= 1'b0;
                rxv_q <= 1'b0;
                rxd_q <= 1'b0; // Same as synchroniser reset: no false fall
            end else begin
                tck_q <= tck_s;
                rck_q <= rck_s;
                rxv_q <= rck_rise ? rxv_s : rxv_q; // Valid at last receive clock
                rxd_q <= rxd_s;
            end
        end

        // Clock pins only count in synchronous mode
        assign tck_fall = sync_mode[g] && tck_q && !tck_s;
        assign rck_rise = sync_mode[g] && !rck_q && rck_s;

        // =============================================================
        // Buffer: a line stall loses no word
        logic [DATA_W-1:0] buf_data;
        logic              buf_valid;
        logic              buf_take;

        two_entry_buffer #(
            .WIDTH     (DATA_W),
            .DEPTH     (2)
        ) u_buf (
            .clk_sys   (clk_sys),
            .reset     (reset),
            .in_data   (tx_data[g]),
            .in_valid  (tx_valid[g]),
            .in_ready  (tx_ready[g]),
            .out_data  (buf_data),
            .out_valid (buf_valid),
            .out_ready (buf_take)
        );

        // =============================================================
        // Transmitter
        bus_port_pkg::tx_state_t tx_state;
        logic [DATA_W-1:0]       tx_shift;
        logic [BW-1:0]           bits_left;
        logic [TW-1:0]           tx_timer;
        logic                    second_half;
        logic                    prev_bit;
        logic                    late_half;
        logic                    txd_r;
        logic                    cts_r;
        logic                    oe_r;
        logic                    step;
        logic                    have_more;
        logic                    can_load;
        logic                    next_bit;
        logic                    fetch_point;
        logic                    start;
        logic                    first_half;

        assign have_more   = bits_left != '0;
        assign can_load    = buf_valid && tx_window[g];
        assign next_bit    = have_more ? tx_shift[DATA_W-1] : buf_data[DATA_W-1];
        // Sync: one bit per clock fall; async: one half-cell per wrap
        assign step        = sync_mode[g] ? tck_fall : (tx_timer == HALF_LAST);
        assign fetch_point = step && (tx_state == bus_port_pkg::TX_SYNC
                             || (tx_state == bus_port_pkg::TX_BITS && (sync_mode[g] || second_half)));
        assign start       = tx_state == bus_port_pkg::TX_IDLE && can_load && (!sync_mode[g] || tck_fall);
        assign buf_take    = start || (fetch_point && !have_more && can_load);

        // MFM: mid-cell transition for one, cell-start transition between two zeros
        always_comb begin
            if (mfm_select[g]) begin
                first_half = (!next_bit && !prev_bit) ? !txd_r : txd_r;
            end else begin
                first_half = !next_bit;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                tx_timer <= '0;
            end else if (tx_state == bus_port_pkg::TX_IDLE || sync_mode[g] || tx_timer == HALF_LAST) begin
                tx_timer <= '0;
            end else begin
                tx_timer <= tx_timer + TW'(1);
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                tx_state    <= bus_port_pkg::TX_IDLE;
                tx_shift    <= '0;
                bits_left   <= '0;
                second_half <= 1'b0;
                prev_bit    <= 1'b1;
                late_half   <= 1'b0;
                txd_r       <= `TXD_REST_LEVEL;
                cts_r       <= `CTS_REST_LEVEL;
            end else if (!tx_window[g]) begin
                // Window shut: drop frame
                tx_state  <= bus_port_pkg::TX_IDLE;
                bits_left <= '0;
                txd_r     <= `TXD_REST_LEVEL;
                cts_r     <= `CTS_REST_LEVEL;
            end else begin
                unique case (tx_state)
                    bus_port_pkg::TX_IDLE: begin
                        if (start && sync_mode[g]) begin
                            tx_state  <= bus_port_pkg::TX_BITS;
                            txd_r     <= buf_data[DATA_W-1];
                            cts_r     <= 1'b1;
                            tx_shift  <= buf_data << 1;
                            bits_left <= BW'(DATA_W - 1);
                        end else if (start) begin
                            // Low half-cell lets the receiver align
                            tx_state  <= bus_port_pkg::TX_SYNC;
                            txd_r     <= 1'b0;
                            cts_r     <= 1'b1;
                            tx_shift  <= buf_data;
                            bits_left <= BYTE_LEN;
                            prev_bit  <= 1'b1;
                        end
                    end
                    bus_port_pkg::TX_SYNC,
                    bus_port_pkg::TX_BITS: begin
                        if (step && tx_state == bus_port_pkg::TX_BITS && !sync_mode[g] && !second_half) begin
                            txd_r       <= late_half;
                            second_half <= 1'b1;
                        end else if (fetch_point && (have_more || can_load)) begin
                            tx_state    <= bus_port_pkg::TX_BITS;
                            prev_bit    <= next_bit;
                            second_half <= 1'b0;
                            txd_r       <= sync_mode[g] ? next_bit : first_half;
                            late_half   <= mfm_select[g] ? (first_half ^ next_bit) : next_bit;
                            if (have_more) begin
                                tx_shift  <= tx_shift << 1;
                                bits_left <= bits_left - BW'(1);
                            end else begin
                                tx_shift  <= buf_data << 1;
                                bits_left <= BW'(DATA_W - 1);
                            end
                        end else if (fetch_point) begin
                            tx_state <= bus_port_pkg::TX_IDLE;
                            txd_r    <= `TXD_REST_LEVEL;
                            cts_r    <= `CTS_REST_LEVEL;
                        end
                    end
                endcase
            end
        end

        // Drivers follow own window one clock late
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                oe_r <= 1'b0;
            end else begin
                oe_r <= tx_window[g];
            end
        end

        assign txd_out[g] = txd_r;
        assign cts_out[g] = cts_r;
        assign txd_oe[g]  = oe_r;
        assign cts_oe[g]  = oe_r;

        // =============================================================
        // Receiver
        bus_port_pkg::rx_state_t rx_state;
        logic [DATA_W-1:0]       rx_shift;
        logic [BW-1:0]           rx_count;
        logic [TW-1:0]           rx_timer;
        logic [RW-1:0]           run_len;
        logic                    align_done;
        logic                    rx_second;
        logic                    rx_first;
        logic [DATA_W-1:0]       rx_data_r;
        logic                    rx_valid_r;
        logic                    rx_err_r;
        logic                    rx_end_r;
        logic                    rx_edge;
        logic                    rx_sample;
        logic                    bit_ready;
        logic                    bit_val;
        logic                    line_quiet;

        assign rx_edge    = rxd_q != rxd_s;
        assign rx_sample  = rx_state == bus_port_pkg::RX_ACTIVE && !rx_edge && rx_timer == HALF_MID;
        // A still level for the idle run ends the frame
        assign line_quiet = rx_sample && run_len == IDLE_RUN - RW'(1);
        assign bit_ready  = sync_mode[g] ? (rck_rise && rxv_s)
                                         : (rx_sample && align_done && rx_second && !line_quiet);
        assign bit_val    = sync_mode[g] ? rxd_s : (mfm_select[g] ? (rx_first ^ rxd_s) : rxd_s);

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                rx_timer <= '0;
                run_len  <= '0;
            end else if (rx_edge || rx_state == bus_port_pkg::RX_IDLE) begin
                rx_timer <= '0;
                run_len  <= '0;
            end else begin
                rx_timer <= (rx_timer == HALF_LAST) ? '0 : rx_timer + TW'(1);
                if (rx_sample) begin
                    run_len <= run_len + RW'(1);
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                rx_state   <= bus_port_pkg::RX_IDLE;
                align_done <= 1'b0;
                rx_second  <= 1'b0;
                rx_first   <= 1'b0;
            end else if (sync_mode[g]) begin
                rx_state <= bus_port_pkg::RX_IDLE;
            end else begin
                unique case (rx_state)
                    bus_port_pkg::RX_IDLE: begin
                        // A fall from the idle level opens a frame
                        if (rxd_q == `LINE_IDLE_LEVEL && !rxd_s) begin
                            rx_state   <= bus_port_pkg::RX_ACTIVE;
                            align_done <= 1'b0;
                            rx_second  <= 1'b0;
                        end
                    end
                    bus_port_pkg::RX_ACTIVE: begin
                        if (line_quiet) begin
                            rx_state <= bus_port_pkg::RX_IDLE;
                        end else if (rx_sample && !align_done) begin
                            align_done <= 1'b1;
                        end else if (rx_sample) begin
                            rx_first  <= rxd_s;
                            rx_second <= !rx_second;
                        end
                    end
                endcase
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                rx_shift   <= '0;
                rx_count   <= '0;
                rx_data_r  <= '0;
                rx_valid_r <= 1'b0;
                rx_err_r   <= 1'b0;
                rx_end_r   <= 1'b0;
            end else begin
                rx_valid_r <= 1'b0;
                rx_err_r   <= 1'b0;
                rx_end_r   <= 1'b0;
                if (bit_ready) begin
                    rx_shift <= {rx_shift[DATA_W-2:0], bit_val};
                    if (rx_count == BYTE_LEN - BW'(1)) begin
                        rx_data_r  <= {rx_shift[DATA_W-2:0], bit_val};
                        rx_valid_r <= 1'b1;
                        rx_count   <= '0;
                    end else begin
                        rx_count <= rx_count + BW'(1);
                    end
                end
                if (sync_mode[g]) begin
                    // Taken on receive clock only
                    if (rck_rise && rxv_s && rx_error_in_s) begin
                        rx_err_r <= 1'b1;
                    end
                    if (rck_rise && rxv_q && !rxv_s) begin
                        rx_end_r <= 1'b1;
                        rx_count <= '0;
                    end
                end else if (line_quiet) begin
                    // Long low breaks idle-high unless RS485
                    rx_end_r <= 1'b1;
                    rx_err_r <= !rxd_s && !rs485_mode[g];
                    rx_count <= '0;
                end
            end
        end

        assign rx_data[g]       = rx_data_r;
        assign rx_data_valid[g] = rx_valid_r;
        assign rx_error_seen[g] = rx_err_r;
        assign rx_frame_end[g]  = rx_end_r;
    end

endmodule

// file: dv/dual_channel_bus_port_sva.sv
// Bus port assertions
`timescale 1ns/1ps
module dual_channel_bus_port_sva (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic [1:0] sync_mode,
    input wire logic [1:0] rs485_mode,
    input wire logic [1:0] tx_window,
    input wire logic [1:0] tx_ready,
    input wire logic [1:0] rx_data_valid,
    input wire logic [1:0] rx_error_seen,
    input wire logic [1:0] rx_frame_end,
    input wire logic [1:0] txd_out,
    input wire logic [1:0] txd_oe,
    input wire logic [1:0] cts_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ==========
    // Transmit and receive relations
    sequence s_start;
        $rose(cts_out[0]) && !sync_mode[0];
    endsequence
    sequence s_pre;
        !txd_out[0] ##1 !txd_out[0];
    endsequence
    AST_OE_LAG: assert property (!$past(reset) |-> txd_oe == $past(tx_window))
        else $error("oe lag");
    AST_QUIET_CH0: assert property (!tx_window[0] |=> txd_out[0] && !cts_out[0])
        else $error("ch0 out of window");
    AST_QUIET_CH1: assert property (!tx_window[1] |=> txd_out[1] && !cts_out[1])
        else $error("ch1 out of window");
    AST_REST: assert property ((~cts_out & ~txd_out) == 2'h0)
        else $error("low without cts");
    AST_PREAMBLE: assert property (s_start |-> s_pre)
        else $error("no preamble");
    AST_PULSE: assert property (rx_data_valid[0] |=> !rx_data_valid[0])
        else $error("pulse too long");
    AST_ERR: assert property (!sync_mode[0] && rx_error_seen[0] |-> rx_frame_end[0] && !rs485_mode[0])
        else $error("bad error");
    AST_READY: assert property ($fell(reset) |-> ##[1:2] tx_ready == 2'h3)
        else $error("no ready");
endmodule

bind dual_channel_bus_port dual_channel_bus_port_sva dual_channel_bus_port_sva_i (
    .clk_sys(clk_sys), .reset(reset), .sync_mode(sync_mode), .rs485_mode(rs485_mode),
    .tx_window(tx_window), .tx_ready(tx_ready), .rx_data_valid(rx_data_valid),
    .rx_error_seen(rx_error_seen), .rx_frame_end(rx_frame_end), .txd_out(txd_out),
    .txd_oe(txd_oe), .cts_out(cts_out));

// file: dv/phy_model.sv
// Single-lane PHY model
`timescale 1ns/1ps
module phy_model (
    input  wire logic       tx_run,
    input  wire logic       txd,
    input  wire logic       cts,
    output logic            tx_clk,
    output logic            rx_clk,
    output logic            rx_dv,
    output logic            rx_er,
    output logic            rxd,
    output logic [7:0]      got
);
    initial {tx_clk, rx_clk, rx_dv, rx_er, rxd, got} = 13'h0;
    // Clock stops between frames
    always #32 tx_clk = tx_run ? ~tx_clk : 1'b0;
    // Capture on rising edge while enabled
    always @(posedge tx_clk) if (cts) got <= {got[6:0], txd};
    task automatic send(input logic [7:0] b, input logic e);
        for (int i = 7; i >= 0; i--) begin
            rxd = b[i];
            rx_dv = 1'b1;
            rx_er = e;
            #32 rx_clk = 1'b1;
            #32 rx_clk = 1'b0;
        end
        rx_dv = 1'b0;
        rx_er = 1'b0;
        rxd = ~b[0];
        #32 rx_clk = 1'b1;
        #32 rx_clk = 1'b0;
    endtask
endmodule

// file: dv/dual_channel_bus_port_test.sv
// Bus port bench
`timescale 1ns/1ps
module dual_channel_bus_port_test;
    logic            clk_sys = 1'b0;
    logic            reset = 1'b1;
    logic            hold_low = 1'b0;
    logic            tx_run = 1'b0;
    logic [1:0]      sync_mode = 2'h2;
    logic [1:0]      mfm_select = 2'h0;
    logic [1:0]      rs485_mode = 2'h0;
    logic [1:0]      tx_window = 2'h0;
    logic [1:0]      tx_valid = 2'h0;
    logic [7:0]      tx_data [2] = '{8'h00, 8'h00};
    logic [7:0]      rx_data [2];
    logic [7:0]      got, r1, q0 [$];
    logic [1:0]      tx_ready, rx_data_valid, rx_error_seen, rx_frame_end, txd_out, txd_oe, cts_out, cts_oe;
    logic            tclk, rclk, dv, er, prxd;
    int              err_count = 0, check_count = 0, fe0 = 0, er0 = 0, er1 = 0, cyc = 0;
    wire logic [1:0] txd_line = (txd_oe & txd_out) | ~txd_oe;
    wire logic [1:0] cts_line = cts_oe & cts_out;
    dual_channel_bus_port #(.HALF_CELL_CYCLES(4), .IDLE_HALF_CELLS(5)) dual_channel_bus_port_i (
        .clk_sys(clk_sys), .reset(reset), .sync_mode(sync_mode), .mfm_select(mfm_select),
        .rs485_mode(rs485_mode), .tx_window(tx_window), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
        .rx_error_seen(rx_error_seen), .rx_frame_end(rx_frame_end), .txd_out(txd_out),
        .txd_oe(txd_oe), .cts_out(cts_out), .cts_oe(cts_oe), .tx_bit_clock_in({2{tclk}}),
        .rx_error_in({2{er}}), .rx_bit_clock_in({2{rclk}}), .rx_valid_in({2{dv}}),
        .rxd_in({prxd, ~hold_low & txd_line[0]}));
    phy_model phy_model_i (.tx_run(tx_run), .txd(txd_line[1]), .cts(cts_line[1]), .tx_clk(tclk),
        .rx_clk(rclk), .rx_dv(dv), .rx_er(er), .rxd(prxd), .got(got));
    always #2.5 clk_sys = ~clk_sys;
    // ==========
    // Monitor and checks
    always @(posedge clk_sys) begin
        if (rx_data_valid[0] === 1'b1) q0.push_back(rx_data[0]);
        if (rx_frame_end[0] === 1'b1) fe0++;
        if (rx_error_seen[0] === 1'b1) er0++;
        if (rx_data_valid[1] === 1'b1) r1 = rx_data[1];
        if (rx_error_seen[1] === 1'b1) er1++;
        if (++cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t byte %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_cnt(input int g, input int e);
        check_count++;
        if (g != e) begin
            err_count++;
            $display("[ERR] %0t count %0d exp %0d", $time, g, e);
        end
    endtask
    // Caller lowers valid after last byte
    task automatic push(input int c, input logic [7:0] b);
        tx_data[c] <= b;
        tx_valid[c] <= 1'b1;
        @(posedge clk_sys);
        for (int k = 0; k < 500 && tx_ready[c] !== 1'b1; k++) @(posedge clk_sys);
    endtask
    task automatic wait_fe(input int n);
        for (int k = 0; k < 3000 && fe0 < n; k++) @(posedge clk_sys);
        chk_cnt(fe0, n);
    endtask
    task automatic t_manch();
        q0.delete();
        tx_window[0] <= 1'b1;
        push(0, 8'hA5);
        push(0, 8'h3C);
        tx_valid[0] <= 1'b0;
        wait_fe(1);
        chk_cnt(q0.size(), 2);
        chk_byte(q0[0], 8'hA5);
        chk_byte(q0[1], 8'h3C);
        $display("manchester done");
    endtask
    task automatic t_fill();
        logic [7:0] e [3] = '{8'h00, 8'hFF, 8'h81};
        int         n = fe0 + 1;
        q0.delete();
        mfm_select[0] <= 1'b1;
        tx_window[0] <= 1'b0;
        push(0, e[0]);
        push(0, e[1]);
        tx_valid[0] <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk_byte({7'h00, tx_ready[0]}, 8'h00);
        chk_byte({6'h00, cts_line[0], txd_line[0]}, 8'h01);
        tx_window[0] <= 1'b1;
        push(0, e[2]);
        tx_valid[0] <= 1'b0;
        wait_fe(n);
        chk_cnt(q0.size(), 3);
        for (int i = 0; i < 3; i++) chk_byte(q0[i], e[i]);
        $display("mfm buffer done");
    endtask
    task automatic t_abort();
        int n = fe0 + 1, e = er0;
        q0.delete();
        push(0, 8'hF0);
        tx_valid[0] <= 1'b0;
        repeat (20) @(posedge clk_sys);
        tx_window[0] <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk_byte({6'h00, cts_line[0], txd_line[0]}, 8'h01);
        wait_fe(n);
        chk_cnt(q0.size(), 0);
        chk_cnt(er0, e);
        $display("abort done");
    endtask
    task automatic t_idle();
        int n = fe0 + 1, e = er0;
        hold_low <= 1'b1;
        wait_fe(n);
        chk_cnt(er0, e + 1);
        hold_low <= 1'b0;
        rs485_mode[0] <= 1'b1;
        repeat (40) @(posedge clk_sys);
        hold_low <= 1'b1;
        wait_fe(n + 1);
        chk_cnt(er0, e + 1);
        hold_low <= 1'b0;
        $display("idle done");
    endtask
    task automatic t_sync();
        int e = er0;
        q0.delete();
        tx_window[1] <= 1'b1;
        tx_run <= 1'b1;
        push(1, 8'hC3);
        tx_valid[1] <= 1'b0;
        for (int k = 0; k < 400 && cts_line[1] !== 1'b1; k++) @(posedge clk_sys);
        for (int k = 0; k < 400 && cts_line[1] !== 1'b0; k++) @(posedge clk_sys);
        tx_run <= 1'b0;
        chk_byte(got, 8'hC3);
        phy_model_i.send(8'h5A, 1'b0);
        repeat (10) @(posedge clk_sys);
        chk_byte(r1, 8'h5A);
        phy_model_i.send(8'h77, 1'b1);
        repeat (10) @(posedge clk_sys);
        chk_cnt(er1 > 0, 1);
        chk_cnt(q0.size() + er0 - e, 0);
        $display("sync done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_manch();
        t_fill();
        t_abort();
        t_idle();
        t_sync();
        summarize();
    end
endmodule
